// >>> drd_pkg.sv
/*
  Shared constants and types of the descriptor ring packet DMA engine:
  descriptor layout, channel map, statistics timing and engine states.
  Assumes 32-bit byte addresses and a 10 MHz system clock.
*/
package drd_pkg;

  // Channel map: 0,1 host_to_card_dir, 2,3 card_to_host_dir
  localparam int NUM_CH      = 4;
  localparam int NUM_TX      = 2;

  // Descriptor layout, byte offsets inside one buffer_descriptor
  localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
  localparam logic [31:0] CTL_OFS    = 32'h0000_0000;
  localparam logic [31:0] BUF_OFS    = 32'h0000_0004;
  localparam logic [31:0] STAT_OFS   = 32'h0000_0008;

  // Control word fields (length counts 32-bit words)
  localparam int CTL_LEN_MSB   = 15;
  localparam int CTL_FIRST_BIT = 16;
  localparam int CTL_LAST_BIT  = 17;
  localparam int CTL_IRQ_BIT   = 18;

  // Status word fields written back on completion
  localparam int STAT_DONE_BIT  = 31;
  localparam int STAT_ERR_BIT   = 30;
  localparam int STAT_SHORT_BIT = 29;
  localparam int STAT_FIRST_BIT = 28;
  localparam int STAT_LAST_BIT  = 27;
  localparam int STAT_USER_LSB  = 16;
  localparam int STAT_LEN_MSB   = 15;

  // Statistics timing
  localparam logic [31:0] CLK_PERIOD_NS = 32'h0000_0064;
  localparam int          SEC_NS        = 1000000000;
  localparam int          SEC_CYCLES    = SEC_NS / 100;

  // Receive FIFO: {chan, user[7:0], last, data[31:0]}
  localparam int FIFO_W     = 42;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_CTL  = 3'h1,
    S_BUF  = 3'h2,
    S_MOVE = 3'h3,
    S_WB   = 3'h4
  } drd_state_t;

endpackage : drd_pkg

// >>> drd_fifo.sv
/*
  Synchronous FIFO with a registered output stage; valid and ready on
  both sides. Assumes one clock and a synchronous active-low reset.
  Holds DEPTH words in the array plus one in the output register.
*/
`timescale 1ns/1ps
module drd_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic [WIDTH-1:0]            dout;
    logic                        ov;
  } drd_fifo_st_t;

  drd_fifo_st_t r_reg, r_next;
  logic push, load;

  // Output stage refills whenever it empties or is taken
  always_comb begin
    r_next     = r_reg;
    in_ready_o = (r_reg.cnt < (AW+1)'(DEPTH)); // Output register is a seventeenth place
    push       = in_valid_i && in_ready_o;
    load       = (!r_reg.ov || out_ready_i) && (r_reg.cnt != '0);
    if (push) begin
      r_next.mem[r_reg.wr] = in_data_i;
      r_next.wr            = r_reg.wr + AW'(1);
    end
    if (load) begin
      r_next.dout = r_reg.mem[r_reg.rd];
      r_next.rd   = r_reg.rd + AW'(1);
      r_next.ov   = 1'b1;
    end else if (r_reg.ov && out_ready_i) begin
      r_next.ov = 1'b0;
    end
    case ({push, load})
      2'b10:   r_next.cnt = r_reg.cnt + (AW+1)'(1);
      2'b01:   r_next.cnt = r_reg.cnt - (AW+1)'(1);
      default: r_next.cnt = r_reg.cnt;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign out_data_o  = r_reg.dout;
  assign out_valid_o = r_reg.ov;

endmodule : drd_fifo

// >>> drd_engine.sv
/*
  Descriptor ring packet DMA engine: four rings, two host_to_card_dir and
  two card_to_host_dir, served one descriptor at a time in round robin.
  Assumes a memory port that answers each request with one ack pulse,
  and host-side pointer and control bits driven from the same clock.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Per channel, done_ptr holds last finished descriptor.
// - Per channel, engine_next_ptr holds next descriptor.
// - Host writes host_submit_ptr per channel.
// - Packets may span several consecutive descriptors.
// - Honour first, last and interrupt descriptor flags; receive honours only the interrupt flag.
// - Consume transmit descriptors up to submit pointer.
// - Receive write-back carries status, flags, user status.
// - Receive write-back reports actual packet length.
// - Memory fault sets error field in write-back, except on transmit data reads (short field only).
// - Transmit only: short error on incomplete fetch.
// - Measure active nanoseconds over last second.
// - Measure nanoseconds waiting for host descriptors.
// - Interrupts raised only when enabled per engine.
// - Four rings: two transmit, two receive.
// - Keep filling receive descriptors as host recycles.
module drd_engine
  import drd_pkg::*;
#(
  parameter int SEC_COUNT = SEC_CYCLES
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_b_i,
  // Host control, one bit or word per channel; init and submit pointer words shared by all channels
  input  wire logic [NUM_CH-1:0]       run_i,
  input  wire logic [NUM_CH-1:0]       irq_en_i,
  input  wire logic [NUM_CH-1:0]       init_we_i,
  input  wire logic [31:0]             init_ptr_i,
  input  wire logic [NUM_CH-1:0]       submit_we_i,
  input  wire logic [31:0]             submit_ptr_i,
  input  wire logic [NUM_CH-1:0][31:0] ring_first_i,
  input  wire logic [NUM_CH-1:0][31:0] ring_last_i,
  // Pointer and statistics status
  output logic [NUM_CH-1:0][31:0]      done_ptr_o,
  output logic [NUM_CH-1:0][31:0]      engine_next_ptr_o,
  output logic [NUM_CH-1:0][31:0]      host_submit_ptr_o,
  output logic [NUM_CH-1:0][31:0]      active_ns_o,
  output logic [NUM_CH-1:0][31:0]      wait_ns_o,
  output logic [NUM_CH-1:0]            irq_o,
  // System memory port
  output logic                         mem_req_o,
  output logic                         mem_we_o,
  output logic [31:0]                  mem_addr_o,
  output logic [31:0]                  mem_wdata_o,
  input  wire logic                    mem_ack_i,
  input  wire logic                    mem_err_i,
  input  wire logic [31:0]             mem_rdata_i,
  // Transmit stream out
  output logic [31:0]                  tx_data_o,
  output logic                         tx_valid_o,
  output logic                         tx_first_o,
  output logic                         tx_last_o,
  output logic                         tx_chan_o,
  input  wire logic                    tx_ready_i,
  // Receive stream in
  input  wire logic [31:0]             rx_data_i,
  input  wire logic                    rx_last_i,
  input  wire logic [7:0]              rx_user_i,
  input  wire logic                    rx_chan_i,
  input  wire logic                    rx_valid_i,
  output logic                         rx_ready_o
);

  typedef struct packed {
    drd_state_t                st;
    logic [1:0]                ch;
    logic [1:0]                rr;
    logic [15:0]               cnt;
    logic [15:0]               len;
    logic [31:0]               buf_addr;
    logic                      f_first;
    logic                      f_last;
    logic                      f_irq;
    logic                      err;
    logic                      shrt;
    logic [7:0]                user;
    logic [NUM_CH-1:0][31:0]   done;
    logic [NUM_CH-1:0][31:0]   next;
    logic [NUM_CH-1:0][31:0]   submit;
    logic [NUM_CH-1:0]         in_pkt;
    logic [NUM_CH-1:0][31:0]   act_cnt;
    logic [NUM_CH-1:0][31:0]   wait_cnt;
    logic [NUM_CH-1:0][31:0]   act_out;
    logic [NUM_CH-1:0][31:0]   wait_out;
    logic [31:0]               sec;
    logic [NUM_CH-1:0]         irq;
    logic                      req;
    logic                      we;
    logic [31:0]               addr;
    logic [31:0]               wdata;
    logic [31:0]               txd;
    logic                      txv;
    logic                      txf;
    logic                      txl;
  } drd_state_st_t;

  drd_state_st_t r_reg, r_next;

  logic [FIFO_W-1:0] fifo_q;
  logic              fifo_v;
  logic              fifo_pop;
  logic [NUM_CH-1:0] elig;
  logic              found;
  logic [1:0]        pick;
  logic [1:0]        idx;
  logic              is_tx;
  logic              sec_end;
  logic [31:0]       stat_w;

  // Receive words wait here; a full FIFO pushes back on the source
  drd_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   ({rx_chan_i, rx_user_i, rx_last_i, rx_data_i}),
    .in_valid_i  (rx_valid_i),
    .in_ready_o  (rx_ready_o),
    .out_data_o  (fifo_q),
    .out_valid_o (fifo_v),
    .out_ready_i (fifo_pop)
  );

  // Next state of the whole engine
  always_comb begin
    r_next   = r_reg;
    fifo_pop = 1'b0;
    found    = 1'b0;
    pick     = 2'h0;
    idx      = 2'h0;
    stat_w   = 32'h0000_0000;
    is_tx    = (r_reg.ch < 2'(NUM_TX));
    sec_end  = (r_reg.sec == 32'(SEC_COUNT - 1));
    r_next.irq = '0;
    if (mem_ack_i) begin
      r_next.req = 1'b0;
    end
    // Host pointer writes; init also clears the completed pointer
    for (int i = 0; i < NUM_CH; i++) begin
      if (submit_we_i[i]) r_next.submit[i] = submit_ptr_i;
      if (init_we_i[i]) begin
        r_next.next[i]   = init_ptr_i;
        r_next.done[i]   = 32'h0000_0000;
        r_next.in_pkt[i] = 1'b0;
      end
      // Receive rings only take work that is already waiting
      elig[i] = run_i[i] && (r_reg.next[i] != r_reg.submit[i]) &&
                (i < NUM_TX || (fifo_v && fifo_q[FIFO_W-1] == 1'(i - NUM_TX)));
    end
    // One-second statistics window, in nanoseconds
    r_next.sec = sec_end ? 32'h0000_0000 : r_reg.sec + 32'h0000_0001;
    // The closing cycle still counts, so a window spans all SEC_COUNT cycles
    for (int i = 0; i < NUM_CH; i++) begin
      if (r_reg.st != S_IDLE && r_reg.ch == 2'(i))
        r_next.act_cnt[i] = r_reg.act_cnt[i] + CLK_PERIOD_NS;
      if (run_i[i] && r_reg.next[i] == r_reg.submit[i])
        r_next.wait_cnt[i] = r_reg.wait_cnt[i] + CLK_PERIOD_NS;
      if (sec_end) begin
        r_next.act_out[i]  = r_next.act_cnt[i];
        r_next.wait_out[i] = r_next.wait_cnt[i];
        r_next.act_cnt[i]  = 32'h0000_0000;
        r_next.wait_cnt[i] = 32'h0000_0000;
      end
    end
    case (r_reg.st)
      S_IDLE: begin
        for (int k = 0; k < NUM_CH; k++) begin
          idx = r_reg.rr + 2'(k);
          if (!found && elig[idx]) begin
            found = 1'b1;
            pick  = idx;
          end
        end
        if (found) begin
          r_next.ch   = pick;
          r_next.rr   = pick + 2'h1;
          r_next.err  = 1'b0;
          r_next.shrt = 1'b0;
          r_next.user = 8'h00;
          r_next.cnt  = 16'h0000;
          r_next.req  = 1'b1;
          r_next.we   = 1'b0;
          r_next.addr = r_reg.next[pick] + CTL_OFS;
          r_next.st   = S_CTL;
        end
      end
      S_CTL: begin
        if (mem_ack_i) begin
          r_next.len     = mem_rdata_i[CTL_LEN_MSB:0];
          r_next.f_irq   = mem_rdata_i[CTL_IRQ_BIT];
          r_next.f_first = is_tx ? mem_rdata_i[CTL_FIRST_BIT] : !r_reg.in_pkt[r_reg.ch];
          r_next.f_last  = is_tx ? mem_rdata_i[CTL_LAST_BIT] : 1'b0;
          r_next.err     = mem_err_i;
          r_next.req     = 1'b1;
          r_next.addr    = r_reg.next[r_reg.ch] + BUF_OFS;
          r_next.st      = S_BUF;
        end
      end
      S_BUF: begin
        if (mem_ack_i) begin
          r_next.buf_addr = mem_rdata_i;
          r_next.err      = r_reg.err || mem_err_i;
          r_next.st       = (r_reg.err || mem_err_i || r_reg.len == 16'h0000) ? S_WB : S_MOVE;
        end
      end
      S_MOVE: begin
        if (is_tx) begin
          // Fetch one word, then hold it on the stream until taken
          if (!r_reg.req && !r_reg.txv && r_reg.cnt != r_reg.len) begin
            r_next.req  = 1'b1;
            r_next.we   = 1'b0;
            r_next.addr = r_reg.buf_addr + {14'h0000, r_reg.cnt, 2'b00};
          end
          if (r_reg.req && mem_ack_i) begin
            if (mem_err_i) begin
              r_next.shrt = 1'b1;
              r_next.st   = S_WB;
            end else begin
              r_next.txd = mem_rdata_i;
              r_next.txv = 1'b1;
              r_next.txf = r_reg.f_first && r_reg.cnt == 16'h0000;
              r_next.txl = r_reg.f_last && (r_reg.cnt + 16'h0001 == r_reg.len);
              r_next.cnt = r_reg.cnt + 16'h0001;
            end
          end
          if (r_reg.txv && tx_ready_i) begin
            r_next.txv = 1'b0;
            if (r_reg.cnt == r_reg.len) r_next.st = S_WB;
          end
        end else begin
          // A packet may end before the buffer does
          if (!r_reg.req && !r_reg.f_last && r_reg.cnt != r_reg.len && fifo_v &&
              fifo_q[FIFO_W-1] == r_reg.ch[0]) begin
            fifo_pop     = 1'b1;
            r_next.req   = 1'b1;
            r_next.we    = 1'b1;
            r_next.addr  = r_reg.buf_addr + {14'h0000, r_reg.cnt, 2'b00};
            r_next.wdata = fifo_q[31:0];
            r_next.f_last = fifo_q[32];
            r_next.user  = fifo_q[40:33];
            r_next.cnt   = r_reg.cnt + 16'h0001;
          end
          if (r_reg.req && mem_ack_i) begin
            r_next.err = r_reg.err || mem_err_i;
            if (r_reg.f_last || r_reg.cnt == r_reg.len || mem_err_i) r_next.st = S_WB;
          end
        end
        if (r_next.st == S_WB) begin
          r_next.req   = 1'b0;
        end
      end
      S_WB: begin
        stat_w[STAT_DONE_BIT]  = 1'b1;
        stat_w[STAT_ERR_BIT]   = r_reg.err;
        stat_w[STAT_SHORT_BIT] = is_tx && r_reg.shrt;
        stat_w[STAT_FIRST_BIT] = r_reg.f_first;
        stat_w[STAT_LAST_BIT]  = r_reg.f_last;
        stat_w[STAT_USER_LSB +: 8]  = r_reg.user;
        stat_w[STAT_LEN_MSB:0] = r_reg.cnt;
        if (!r_reg.req && !r_reg.we || r_reg.addr != r_reg.next[r_reg.ch] + STAT_OFS) begin
          r_next.req   = 1'b1;
          r_next.we    = 1'b1;
          r_next.addr  = r_reg.next[r_reg.ch] + STAT_OFS;
          r_next.wdata = stat_w;
        end else if (r_reg.req && mem_ack_i) begin
          r_next.done[r_reg.ch] = r_reg.next[r_reg.ch];
          r_next.next[r_reg.ch] = (r_reg.next[r_reg.ch] == ring_last_i[r_reg.ch]) ?
                                  ring_first_i[r_reg.ch] :
                                  r_reg.next[r_reg.ch] + DESC_BYTES;
          if (!is_tx) r_next.in_pkt[r_reg.ch] = !r_reg.f_last;
          r_next.irq[r_reg.ch] = r_reg.f_irq && irq_en_i[r_reg.ch];
          r_next.we = 1'b0;
          r_next.st = S_IDLE;
        end
      end
      default: r_next.st = S_IDLE;
    endcase
  end

  // Single register bank for all engine state
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done_ptr_o        = r_reg.done;
  assign engine_next_ptr_o = r_reg.next;
  assign host_submit_ptr_o = r_reg.submit;
  assign active_ns_o       = r_reg.act_out;
  assign wait_ns_o         = r_reg.wait_out;
  assign irq_o             = r_reg.irq;
  assign mem_req_o         = r_reg.req;
  assign mem_we_o          = r_reg.we;
  assign mem_addr_o        = r_reg.addr;
  assign mem_wdata_o       = r_reg.wdata;
  assign tx_data_o         = r_reg.txd;
  assign tx_valid_o        = r_reg.txv;
  assign tx_first_o        = r_reg.txf;
  assign tx_last_o         = r_reg.txl;
  assign tx_chan_o         = r_reg.ch[0];

  // Checks on the engine's own behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_wb_ack;
    r_reg.st == S_WB && r_reg.req && r_reg.we && mem_ack_i;
  endsequence
  sequence s_tx_stall;
    r_reg.txv && !tx_ready_i;
  endsequence

  property p_done_after_wb;
    $changed(r_reg.done) && !$past(|init_we_i) |-> $past(r_reg.st) == S_WB;
  endproperty
  a_done_after_wb: assert property (p_done_after_wb)
    else $error("done pointer moved without status write-back");

  property p_irq_enabled;
    |(r_reg.irq & ~$past(irq_en_i)) == 1'b0;
  endproperty
  a_irq_enabled: assert property (p_irq_enabled)
    else $error("interrupt raised while disabled");

  property p_no_start_at_submit;
    r_reg.st == S_IDLE && r_next.st == S_CTL |-> r_reg.next[r_next.ch] != r_reg.submit[r_next.ch];
  endproperty
  a_no_start_at_submit: assert property (p_no_start_at_submit)
    else $error("descriptor started at submit pointer");

  property p_wrap;
    s_wb_ack ##0 (r_reg.next[r_reg.ch] == ring_last_i[r_reg.ch] && init_we_i == '0)
      |=> r_reg.next[$past(r_reg.ch)] == $past(ring_first_i[r_reg.ch]);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("next pointer did not wrap");

  property p_short_tx_only;
    r_reg.req && r_reg.we && r_reg.wdata[STAT_SHORT_BIT] && r_reg.st == S_WB |-> r_reg.ch < 2'h2;
  endproperty
  a_short_tx_only: assert property (p_short_tx_only)
    else $error("short error on receive channel");

  property p_status_done;
    s_wb_ack |-> r_reg.wdata[STAT_DONE_BIT] && r_reg.wdata[STAT_LEN_MSB:0] == r_reg.cnt;
  endproperty
  a_status_done: assert property (p_status_done)
    else $error("write-back lacks completion or length");

  property p_tx_hold;
    s_tx_stall |=> r_reg.txv && $stable(r_reg.txd) && $stable(r_reg.txl);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit word dropped under back-pressure");

  property p_done_follows;
    s_wb_ack ##0 (init_we_i == '0) |=> r_reg.done[$past(r_reg.ch)] == $past(r_reg.next[r_reg.ch])
      ##1 r_reg.st == S_IDLE || r_reg.st == S_CTL;
  endproperty
  a_done_follows: assert property (p_done_follows)
    else $error("done pointer not updated after write-back");

endmodule : drd_engine

// >>> drd_mem_model.sv
/*
  System memory partner: a word RAM answering the engine's requests.
  Assumes one clock; latency and fault address are set by the bench.
*/
`timescale 1ns/1ps
module drd_mem_model (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // Engine request side
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o,
  output logic             err_o,
  output logic [31:0]      rdata_o,
  // Bench control
  input  wire logic [3:0]  lat_i,
  input  wire logic [31:0] err_addr_i
);
  logic [31:0] ram [0:1023];
  logic [3:0]  cnt;

  // One ack per request after lat_i wait cycles; read data never lingers
  always @(posedge sys_clk_i) begin
    ack_o   <= 1'b0;
    err_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    if (!rst_b_i) begin
      cnt <= 4'h0;
    end else if (req_i && !ack_o) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat_i) begin
        cnt     <= 4'h0;
        ack_o   <= 1'b1;
        err_o   <= (addr_i === err_addr_i); // Fault only where the bench asks
        rdata_o <= ram[addr_i[11:2]];
        if (we_i) begin
          ram[addr_i[11:2]] <= wdata_i;
        end
      end
    end
  end
endmodule : drd_mem_model

// >>> tb_top.sv
/*
  Bench for the descriptor ring DMA engine: host bits, streams, memory.
  Assumes drd_mem_model as system memory and a statistics window of 50.
*/
`timescale 1ns/1ps
module tb_top;
  import drd_pkg::*;
  localparam int SEC = 50;
  logic                    clk, rst_b, mreq, mwe, mack, merr, txv, txf, txl, txc, txr;
  logic                    rxl, rxc, rxv, rxr;
  logic [NUM_CH-1:0]       run, ien, iwe, swe, irq;
  logic [31:0]             iptr, sptr, maddr, mwd, mrd, txd, rxd, eaddr;
  logic [NUM_CH-1:0][31:0] rf, rl, dptr, nptr, hsp, act, wt;
  logic [7:0]              rxu;
  logic [3:0]              lat;
  int                      failures, n_compared, irqs, n;
  logic [34:0]             txq [$];

  drd_engine #(.SEC_COUNT(SEC)) dut (
    .sys_clk_i(clk), .rst_b_i(rst_b), .run_i(run), .irq_en_i(ien),
    .init_we_i(iwe), .init_ptr_i(iptr), .submit_we_i(swe), .submit_ptr_i(sptr),
    .ring_first_i(rf), .ring_last_i(rl), .done_ptr_o(dptr), .engine_next_ptr_o(nptr),
    .host_submit_ptr_o(hsp), .active_ns_o(act), .wait_ns_o(wt), .irq_o(irq),
    .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwd),
    .mem_ack_i(mack), .mem_err_i(merr), .mem_rdata_i(mrd),
    .tx_data_o(txd), .tx_valid_o(txv), .tx_first_o(txf), .tx_last_o(txl),
    .tx_chan_o(txc), .tx_ready_i(txr), .rx_data_i(rxd), .rx_last_i(rxl),
    .rx_user_i(rxu), .rx_chan_i(rxc), .rx_valid_i(rxv), .rx_ready_o(rxr));

  drd_mem_model mem (
    .sys_clk_i(clk), .rst_b_i(rst_b), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
    .wdata_i(mwd), .ack_o(mack), .err_o(merr), .rdata_o(mrd), .lat_i(lat),
    .err_addr_i(eaddr));

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Stream sink stalls every other cycle; interrupts are counted
  always @(posedge clk) begin
    if (!rst_b) begin
      txr  <= 1'b0;
      irqs <= 0;
    end else begin
      txr <= ~txr;
      if (txv && txr) begin
        txq.push_back({txc, txf, txl, txd});
      end
      irqs <= irqs + $countones(irq);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic wait_ptr(input int ch, input logic [31:0] p);
    int i;
    for (i = 0; i < 3000 && dptr[ch] !== p; i++) @(posedge clk);
    if (i == 3000) begin
      failures++;
      $display("[ERR] %0t completion never seen", $time);
      print_verdict();
    end
  endtask : wait_ptr

  // Places one descriptor: control, buffer address, cleared status
  task automatic desc(input logic [31:0] a, input logic [31:0] ctl, input logic [31:0] b);
    mem.ram[a[11:2]] = ctl;
    mem.ram[a[11:2] + 10'h1] = b;
    mem.ram[a[11:2] + 10'h2] = 32'h0000_0000;
  endtask : desc

  // Pointer setup always precedes enabling the channel
  task automatic setup(input int ch, input logic [31:0] nxt, input logic [31:0] sub);
    @(posedge clk);
    iwe[ch] <= 1'b1;
    iptr    <= nxt;
    @(posedge clk);
    iwe[ch] <= 1'b0;
    swe[ch] <= 1'b1;
    sptr    <= sub;
    @(posedge clk);
    swe[ch] <= 1'b0;
    @(posedge clk);
    chk(dptr[ch], 32'h0000_0000);
    chk(hsp[ch], sub);
    run[ch] <= 1'b1;
  endtask : setup

  task automatic tx_chk(input logic [34:0] e);
    logic [34:0] g;
    g = (txq.size() > 0) ? txq.pop_front() : 35'h0;
    chk({g[31:0]}, e[31:0]);
    chk({29'h0, g[34:32]}, {29'h0, e[34:32]});
  endtask : tx_chk

  // Two-descriptor packet, stall at the submit pointer, then wrap
  task automatic t_tx();
    desc(32'h0000_0100, 32'h0005_0002, 32'h0000_0400);
    desc(32'h0000_0110, 32'h0002_0001, 32'h0000_0500);
    desc(32'h0000_0120, 32'h0007_0001, 32'h0000_0600);
    mem.ram[256] = 32'hA000_0000;
    mem.ram[257] = 32'hA000_0001;
    mem.ram[320] = 32'hB000_0000;
    mem.ram[384] = 32'hC000_0000;
    setup(0, 32'h0000_0100, 32'h0000_0120);
    wait_ptr(0, 32'h0000_0110);
    chk(mem.ram[66] & 32'hF800_FFFF, 32'h9000_0002);
    chk(mem.ram[70] & 32'hF800_FFFF, 32'h8800_0001);
    repeat (20) @(posedge clk);
    chk(nptr[0], 32'h0000_0120);
    tx_chk({3'b010, 32'hA000_0000});
    tx_chk({3'b000, 32'hA000_0001});
    tx_chk({3'b001, 32'hB000_0000});
    chk(32'(irqs), 32'h0000_0001);
    swe[0] <= 1'b1;
    sptr   <= 32'h0000_0100;
    @(posedge clk);
    swe[0] <= 1'b0;
    wait_ptr(0, 32'h0000_0120);
    @(posedge clk);
    chk(dptr[0], 32'h0000_0120);
    chk(nptr[0], 32'h0000_0100);
    chk(mem.ram[74] & 32'hF800_FFFF, 32'h9800_0001);
    tx_chk({3'b011, 32'hC000_0000});
    chk(32'(irqs), 32'h0000_0002);
  endtask : t_tx

  // Fault on the second data read of a transmit descriptor
  task automatic t_short();
    desc(32'h0000_0140, 32'h0007_0003, 32'h0000_0700);
    eaddr <= 32'h0000_0704;
    setup(1, 32'h0000_0140, 32'h0000_0150);
    wait_ptr(1, 32'h0000_0140);
    chk(mem.ram[82] & 32'hE000_0000, 32'hA000_0000);
    chk(32'(irqs), 32'h0000_0002);
    eaddr <= 32'hFFFF_FFFC;
    txq.delete();
  endtask : t_short

  task automatic send(input logic ch, input logic [31:0] d, input logic last);
    int i;
    @(posedge clk);
    rxv <= 1'b1;
    rxd <= d;
    rxl <= last;
    rxc <= ch;
    for (i = 0; i < 500; i++) begin
      @(negedge clk);
      if (rxr) break;
    end
    if (i == 500) begin
      failures++;
      $display("[ERR] %0t receive stream never accepted", $time);
      print_verdict();
    end
    @(posedge clk);
    rxv <= 1'b0;
  endtask : send

  // Short packet, then a packet whose write hits a memory fault
  task automatic t_rx();
    desc(32'h0000_0200, 32'h0000_0004, 32'h0000_0800);
    desc(32'h0000_0210, 32'h0000_0004, 32'h0000_0900);
    setup(2, 32'h0000_0200, 32'h0000_0220);
    send(1'b0, 32'hD000_0000, 1'b0);
    send(1'b0, 32'hD000_0001, 1'b1);
    wait_ptr(2, 32'h0000_0200);
    chk(mem.ram[512], 32'hD000_0000);
    chk(mem.ram[513], 32'hD000_0001);
    chk(mem.ram[130], 32'h98A5_0002);
    eaddr <= 32'h0000_0904;
    send(1'b0, 32'hE000_0000, 1'b0);
    send(1'b0, 32'hE000_0001, 1'b1);
    wait_ptr(2, 32'h0000_0210);
    chk(mem.ram[134] & 32'hC000_0000, 32'hC000_0000);
    eaddr <= 32'hFFFF_FFFC;
  endtask : t_rx

  // Fill the receive buffer before its channel is set up, then drain slowly
  task automatic t_fifo();
    desc(32'h0000_0300, 32'h0000_0020, 32'h0000_0B00);
    rxv    <= 1'b1;
    rxc    <= 1'b1;
    rxl    <= 1'b0;
    rxd    <= 32'h0000_0001;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (!rxr) break;
      @(posedge clk);
      rxd <= 32'(n + 2);
    end
    @(posedge clk);
    rxv <= 1'b0;
    chk(32'(n), 32'(FIFO_DEPTH + 1));
    lat <= 4'h3;
    setup(3, 32'h0000_0300, 32'h0000_0310);
    send(1'b1, 32'h0000_0012, 1'b1);
    wait_ptr(3, 32'h0000_0300);
    chk(mem.ram[704], 32'h0000_0001);
    chk(mem.ram[721], 32'h0000_0012);
    chk(mem.ram[194], 32'h98A5_0012);
  endtask : t_fifo

  // Idle window: channel 0 waits on the host the whole time
  task automatic t_stats();
    repeat (3 * SEC) @(posedge clk);
    chk(wt[0], 32'(SEC * 100));
    chk(act[0], 32'h0000_0000);
  endtask : t_stats

  initial begin
    {run, ien, iwe, swe, rxl, rxc, rxv} = '0;
    {iptr, sptr, rxd, failures, n_compared} = '0;
    rst_b = 1'b0;
    ien   = 4'h1;
    rxu   = 8'hA5;
    lat   = 4'h2;
    eaddr = 32'hFFFF_FFFC;
    rf    = {32'h0000_0300, 32'h0000_0200, 32'h0000_0140, 32'h0000_0100};
    rl    = {32'h0000_0310, 32'h0000_0220, 32'h0000_0150, 32'h0000_0120};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({31'h0, mreq}, 32'h0000_0000);
    t_tx();
    t_short();
    t_rx();
    t_fifo();
    t_stats();
    print_verdict();
  end
endmodule : tb_top
